// [eeprom_i2c_pkg.sv]
/*
  Shared constants for the EEPROM serial-bus slave front end and the bus master.
  Assumes a single 25 MHz system clock on both ends; all times below turn into
  cycle counts of that clock.
*/
package eeprom_i2c_pkg;
  localparam int unsigned CLK_NS                 = 40;
  localparam int unsigned GLITCH_NS              = 100;
  localparam logic [2:0]  FILT_CYC               = 3'((GLITCH_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned POWER_UP_NS            = 100000;
  localparam logic [11:0] PU_CYC                 = 12'((POWER_UP_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned INTERNAL_WRITE_TIME_NS = 5000000;
  localparam int unsigned WR_CYC                 = INTERNAL_WRITE_TIME_NS / CLK_NS;
  localparam int unsigned WR_CNT_W               = 17;
  localparam int unsigned SCL_QTR_NS             = 1000;
  localparam logic [4:0]  SCL_QTR_CYC            = 5'(SCL_QTR_NS / CLK_NS);
  localparam logic [3:0]  TYPE_CODE              = 4'ha;
  localparam logic [3:0]  BYTE_BITS              = 4'h8;
  localparam logic [3:0]  XFER_BITS              = 4'h9;
  // Synchroniser lanes of the slave's outside inputs.
  localparam int unsigned IX_SCL                 = 0;
  localparam int unsigned IX_SDA                 = 1;
  localparam int unsigned IX_SUP                 = 2;
  localparam int unsigned IX_WP                  = 3;
  localparam int unsigned IX_SEL                 = 4;
  localparam logic [6:0]  SYNC_RST               = 7'h03;
  // Master register map.
  localparam logic [3:0]  CTRL_OFS               = 4'h0;
  localparam logic [3:0]  TXD_OFS                = 4'h4;
  localparam logic [3:0]  STAT_OFS               = 4'h8;
  localparam int unsigned CMD_START              = 0;
  localparam int unsigned CMD_WRITE              = 1;
  localparam int unsigned CMD_READ               = 2;
  localparam int unsigned CMD_STOP               = 3;
  localparam int unsigned CMD_NACK               = 4;
  localparam int unsigned ST_BUSY                = 0;
  localparam int unsigned ST_ACTIVE              = 1;
  localparam int unsigned ST_NACK                = 2;
  localparam int unsigned ST_RX                  = 8;
  localparam logic [1:0]  RESP_OKAY              = 2'b00;
  localparam logic [1:0]  RESP_SLVERR            = 2'b10;
endpackage

// [i2c_link_if.sv]
/*
  Two-wire link between the bus master and the EEPROM slave front end.
  Both wires are open drain with a pull-up: a line is low while any party
  enables a low drive, and reads high otherwise.
*/
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// [eeprom_i2c_slave.sv]
/*
  Slave front end of a small serial EEPROM: condition detection, glitch
  filtering, address decode, acknowledge, write-protect and busy polling.
  Assumes the memory array sits outside: it takes written bytes from the
  strobe outputs and presents the current read byte on rd_byte at all times.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01 - START is data falling while clock high
// RULE_02 - STOP is data rising while clock high
// RULE_03 - Data change during clock high is condition
// RULE_04 - Ignore the bus until a START
// RULE_05 - Master makes clock and all conditions
// RULE_06 - Master starts only on an idle bus
// RULE_07 - Accept address only with type code 1010
// RULE_08 - Last address bit: one reads, zero writes
// RULE_09 - Select bits match pins or give high address
// RULE_10 - Sample on clock rise, drive after fall
// RULE_11 - Zero pulls low, one releases, open drain
// RULE_12 - Hold reset while supply is below trigger
// RULE_13 - Ready within 0.1 ms of stable supply
// RULE_14 - Filter pulses up to 100 ns on inputs
// RULE_15 - Write protect high inhibits all writes
// RULE_16 - Undriven select pins read as low
// RULE_17 - Acknowledge matching address and written bytes
// RULE_18 - Read: release at ninth clock, continue on acknowledge
// RULE_19 - Not-acknowledge address while internal write busy
// RULE_20 - Protect at first data byte withholds acknowledge
// RULE_21 - Busy interval from configurable write-time counter
// RULE_22 - START restarts address; STOP returns to idle
module eeprom_i2c_slave #(
  parameter int unsigned WR_CYCLES = eeprom_i2c_pkg::WR_CYC,
  parameter logic [2:0]  SEL_USED  = 3'h7
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  i2c_link_if.slave       link,
  input  wire logic       supply_ok,
  input  wire logic       write_protect,
  input  wire logic [2:0] device_select_pins,
  input  wire logic [7:0] rd_byte,
  output logic            ready_ff,
  output logic            busy_ff,
  output logic            wr_valid_ff,
  output logic            wr_first_ff,
  output logic [7:0]      wr_byte_ff,
  output logic            rd_req_ff,
  output logic [2:0]      high_memory_address_bits_ff
);
  import eeprom_i2c_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_ADDR, S_WR, S_ACK_WR, S_RD, S_RD_ACK} state_t;

  function automatic logic addr_match(input logic [7:0] a, input logic [2:0] pins);
    addr_match = (a[7:4] == TYPE_CODE) && (((a[3:1] ^ pins) & SEL_USED) == 3'h0);
  endfunction

  logic [6:0]          meta_ff;
  logic [6:0]          syn_ff;
  logic                por_rst;
  logic [1:0]          flt_ff;
  logic [1:0]          prev_ff;
  logic [2:0]          fcnt_ff [2];
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic [11:0]         pu_cnt_ff;
  logic [WR_CNT_W-1:0] wr_cnt_ff;
  state_t              state_ff;
  logic [3:0]          bit_cnt_ff;
  logic [7:0]          sr_ff;
  logic                rw_ff;
  logic [1:0]          wcnt_ff;
  logic                prot_ff;
  logic                dirty_ff;
  logic                cont_ff;
  logic                sda_oe_ff;
  logic                sda_out_ff;
  logic                load_rd;

  // Pull-downs on the protect and select pins live at the pads; the lanes
  // reset to low so an unpowered pin never looks high. [RULE_15] [RULE_16]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= SYNC_RST;
      syn_ff  <= SYNC_RST;
    end else begin
      meta_ff <= {device_select_pins, write_protect, supply_ok, link.sda, link.scl};
      syn_ff  <= meta_ff;
    end
  end

  assign por_rst = !aresetn || !syn_ff[IX_SUP]; // [RULE_12]

  // A level is taken only after it has differed for more than the glitch
  // width, which costs about 160 ns of latency on every edge. [RULE_14]
  always_ff @(posedge aclk) begin
    if (por_rst) begin
      flt_ff     <= 2'h3;
      prev_ff    <= 2'h3;
      fcnt_ff[0] <= 3'h0;
      fcnt_ff[1] <= 3'h0;
    end else begin
      prev_ff <= flt_ff;
      for (int i = 0; i < 2; i++) begin
        if (syn_ff[i] == flt_ff[i]) begin
          fcnt_ff[i] <= 3'h0;
        end else if (fcnt_ff[i] == FILT_CYC) begin
          flt_ff[i]  <= syn_ff[i];
          fcnt_ff[i] <= 3'h0;
        end else begin
          fcnt_ff[i] <= fcnt_ff[i] + 3'h1;
        end
      end
    end
  end

  assign scl_rise  = flt_ff[IX_SCL] && !prev_ff[IX_SCL];
  assign scl_fall  = !flt_ff[IX_SCL] && prev_ff[IX_SCL];
  assign start_det = !flt_ff[IX_SDA] && prev_ff[IX_SDA] && flt_ff[IX_SCL] && prev_ff[IX_SCL]; // [RULE_01] [RULE_03]
  assign stop_det  = flt_ff[IX_SDA] && !prev_ff[IX_SDA] && flt_ff[IX_SCL] && prev_ff[IX_SCL]; // [RULE_02] [RULE_03]

  always_ff @(posedge aclk) begin
    if (por_rst) begin
      pu_cnt_ff <= 12'h000;
      ready_ff  <= 1'b0;
    end else if (pu_cnt_ff == PU_CYC - 12'h001) begin
      ready_ff  <= 1'b1; // [RULE_13]
    end else begin
      pu_cnt_ff <= pu_cnt_ff + 12'h001;
    end
  end

  // Internal write time, started by the STOP that ends a real write.
  always_ff @(posedge aclk) begin
    if (por_rst) begin
      busy_ff   <= 1'b0;
      wr_cnt_ff <= '0;
    end else if (stop_det && dirty_ff) begin
      busy_ff   <= 1'b1; // [RULE_21]
      wr_cnt_ff <= '0;
    end else if (busy_ff) begin
      wr_cnt_ff <= wr_cnt_ff + WR_CNT_W'(1);
      if (wr_cnt_ff == WR_CNT_W'(WR_CYCLES - 1)) begin
        busy_ff <= 1'b0; // [RULE_21]
      end
    end
  end

  assign load_rd = scl_fall && ((state_ff == S_ACK_ADDR && rw_ff) || (state_ff == S_RD_ACK && cont_ff));

  always_ff @(posedge aclk) begin
    if (por_rst) begin
      state_ff                    <= S_IDLE;
      bit_cnt_ff                  <= 4'h0;
      sr_ff                       <= 8'h00;
      rw_ff                       <= 1'b0;
      wcnt_ff                     <= 2'h0;
      prot_ff                     <= 1'b0;
      dirty_ff                    <= 1'b0;
      cont_ff                     <= 1'b0;
      sda_oe_ff                   <= 1'b0;
      wr_valid_ff                 <= 1'b0;
      wr_first_ff                 <= 1'b0;
      wr_byte_ff                  <= 8'h00;
      rd_req_ff                   <= 1'b0;
      high_memory_address_bits_ff <= 3'h0;
    end else begin
      wr_valid_ff <= 1'b0;
      rd_req_ff   <= 1'b0;
      if (!ready_ff) begin
        state_ff <= S_IDLE;
      end else if (start_det) begin
        state_ff   <= S_ADDR; // [RULE_22]
        bit_cnt_ff <= 4'h0;
        sda_oe_ff  <= 1'b0;
        wcnt_ff    <= 2'h0;
        prot_ff    <= 1'b0;
        dirty_ff   <= 1'b0;
      end else if (stop_det) begin
        state_ff  <= S_IDLE; // [RULE_22]
        sda_oe_ff <= 1'b0;
        dirty_ff  <= 1'b0;
      end else if (load_rd) begin
        // Open drain: a one is sent by releasing the line. [RULE_11] [RULE_10]
        state_ff   <= S_RD;
        sr_ff      <= {rd_byte[6:0], 1'b0};
        sda_oe_ff  <= !rd_byte[7];
        bit_cnt_ff <= 4'h1;
        rd_req_ff  <= 1'b1;
      end else begin
        case (state_ff)
          S_IDLE: begin
            sda_oe_ff <= 1'b0; // [RULE_04]
          end
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              sr_ff      <= {sr_ff[6:0], flt_ff[IX_SDA]}; // [RULE_10]
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
              if (state_ff == S_ADDR) begin
                if (addr_match(sr_ff, syn_ff[IX_SEL+:3]) && !busy_ff) begin // [RULE_07] [RULE_09] [RULE_19]
                  state_ff                    <= S_ACK_ADDR;
                  sda_oe_ff                   <= 1'b1; // [RULE_17]
                  rw_ff                       <= sr_ff[0]; // [RULE_08]
                  high_memory_address_bits_ff <= sr_ff[3:1] & ~SEL_USED; // [RULE_09]
                end else begin
                  state_ff <= S_IDLE;
                end
              end else if (wcnt_ff != 2'h0 && prot_ff) begin
                state_ff <= S_IDLE; // [RULE_20] [RULE_15]
              end else begin
                state_ff    <= S_ACK_WR;
                sda_oe_ff   <= 1'b1; // [RULE_17]
                wr_valid_ff <= 1'b1;
                wr_first_ff <= (wcnt_ff == 2'h0);
                wr_byte_ff  <= sr_ff;
                dirty_ff    <= dirty_ff || (wcnt_ff != 2'h0);
                wcnt_ff     <= (wcnt_ff == 2'h0) ? 2'h1 : 2'h2;
              end
            end
          end
          S_ACK_ADDR, S_ACK_WR: begin
            if (scl_fall) begin
              state_ff   <= S_WR;
              sda_oe_ff  <= 1'b0;
              bit_cnt_ff <= 4'h0;
              if (state_ff == S_ACK_WR && wcnt_ff == 2'h1) begin
                prot_ff <= syn_ff[IX_WP]; // [RULE_20]
              end
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt_ff == BYTE_BITS) begin
                state_ff  <= S_RD_ACK;
                sda_oe_ff <= 1'b0; // [RULE_18]
              end else begin
                sda_oe_ff  <= !sr_ff[7]; // [RULE_10] [RULE_11]
                sr_ff      <= {sr_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          S_RD_ACK: begin
            if (scl_rise) begin
              cont_ff <= !flt_ff[IX_SDA]; // [RULE_18]
            end else if (scl_fall) begin
              state_ff <= S_IDLE; // [RULE_18]
            end
          end
          default: begin
            state_ff <= S_IDLE;
          end
        endcase
      end
    end
  end

  // The slave never drives a one; the output data value stays low.
  always_ff @(posedge aclk) begin
    sda_out_ff <= 1'b0; // [RULE_11]
  end

  assign link.s_sda_o  = sda_out_ff;
  assign link.s_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// [i2c_bus_master.sv]
/*
  Two-wire bus master driven from AXI4-Lite registers: START, byte write,
  byte read and STOP commands, run in that order when several are posted.
  Assumes it is the only master on the link and that software waits for the
  slave's power-up time before the first command.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  i2c_link_if.master       link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import eeprom_i2c_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_START, M_XFER, M_STOP} mstate_t;

  logic [3:0] aw_addr_ff;
  logic [7:0] w_data_ff;
  logic       w_lane0_ff;
  logic       aw_got_ff;
  logic       w_got_ff;
  logic       do_wr;
  logic       ctrl_wr;
  logic [3:0] cmd_ff;
  logic       nack_tx_ff;
  logic [7:0] txd_ff;
  logic [7:0] rx_ff;
  logic       nack_rx_ff;
  logic       active_ff;
  logic       busy;
  mstate_t    state_ff;
  logic [4:0] div_ff;
  logic [1:0] qtr_ff;
  logic [3:0] bit_cnt_ff;
  logic [8:0] shift_ff;
  logic [8:0] rcv_ff;
  logic       scl_oe_ff;
  logic       sda_oe_ff;
  logic       line_lo_ff;
  logic [1:0] sda_sync_ff;
  logic       qtick;

  assign busy    = (cmd_ff != 4'h0) || (state_ff != M_IDLE);
  assign do_wr   = aw_got_ff && w_got_ff && !bvalid;
  assign ctrl_wr = do_wr && aw_addr_ff == CTRL_OFS && w_lane0_ff && !busy;

  // Address and data are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      txd_ff     <= 8'h00;
    end else begin
      if (awvalid && awready) begin
        awready    <= 1'b0;
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wready     <= 1'b0;
        w_got_ff   <= 1'b1;
        w_data_ff  <= wdata[7:0];
        w_lane0_ff <= wstrb[0];
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid    <= 1'b1;
        if (aw_addr_ff == TXD_OFS) begin
          bresp <= RESP_OKAY;
          if (w_lane0_ff) begin
            txd_ff <= w_data_ff;
          end
        end else if (aw_addr_ff == CTRL_OFS || aw_addr_ff == STAT_OFS) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      if (araddr == CTRL_OFS) begin
        rdata <= {27'h0, nack_tx_ff, cmd_ff};
      end else if (araddr == TXD_OFS) begin
        rdata <= {24'h0, txd_ff};
      end else if (araddr == STAT_OFS) begin
        rdata <= {16'h0, rx_ff, 5'h0, nack_rx_ff, active_ff, busy};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // The master alone makes the clock, by a divider from aclk. [RULE_05]
  assign qtick = (div_ff == SCL_QTR_CYC - 5'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= M_IDLE;
      cmd_ff     <= 4'h0;
      nack_tx_ff <= 1'b0;
      div_ff     <= 5'h00;
      qtr_ff     <= 2'h0;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 9'h1ff;
      rcv_ff     <= 9'h000;
      rx_ff      <= 8'h00;
      nack_rx_ff <= 1'b0;
      active_ff  <= 1'b0;
      scl_oe_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else if (state_ff == M_IDLE) begin
      div_ff     <= 5'h00;
      qtr_ff     <= 2'h0;
      bit_cnt_ff <= 4'h0;
      if (ctrl_wr) begin
        cmd_ff     <= w_data_ff[3:0];
        nack_tx_ff <= w_data_ff[CMD_NACK];
      end else if (cmd_ff[CMD_START]) begin
        state_ff <= M_START;
      end else if (cmd_ff[CMD_WRITE]) begin
        state_ff <= M_XFER;
        shift_ff <= {txd_ff, 1'b1}; // [RULE_11]
      end else if (cmd_ff[CMD_READ]) begin
        state_ff <= M_XFER;
        shift_ff <= {8'hff, nack_tx_ff}; // [RULE_18]
      end else if (cmd_ff[CMD_STOP]) begin
        state_ff <= M_STOP;
      end
    end else begin
      div_ff <= qtick ? 5'h00 : div_ff + 5'h01;
      if (qtick) begin
        qtr_ff <= qtr_ff + 2'h1;
        case (state_ff)
          M_START: begin
            // Release data, raise clock, then pull data low while clock high.
            if (qtr_ff == 2'h0) sda_oe_ff <= 1'b0;
            if (qtr_ff == 2'h1) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h2) sda_oe_ff <= 1'b1; // [RULE_01]
            if (qtr_ff == 2'h3) begin
              scl_oe_ff         <= 1'b1;
              active_ff         <= 1'b1;
              cmd_ff[CMD_START] <= 1'b0;
              state_ff          <= M_IDLE;
            end
          end
          M_XFER: begin
            // Data changes only while the clock is low. [RULE_03]
            if (qtr_ff == 2'h0) sda_oe_ff <= !shift_ff[8];
            if (qtr_ff == 2'h1) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h3) begin
              scl_oe_ff  <= 1'b1;
              rcv_ff     <= {rcv_ff[7:0], sda_sync_ff[1]};
              shift_ff   <= {shift_ff[7:0], 1'b1};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == XFER_BITS - 4'h1) begin
                rx_ff      <= rcv_ff[7:0];
                nack_rx_ff <= sda_sync_ff[1];
                cmd_ff     <= cmd_ff[CMD_WRITE] ? (cmd_ff & 4'hd) : (cmd_ff & 4'hb);
                state_ff   <= M_IDLE;
              end
            end
          end
          default: begin
            if (qtr_ff == 2'h0) sda_oe_ff <= 1'b1;
            if (qtr_ff == 2'h1) scl_oe_ff <= 1'b0;
            if (qtr_ff == 2'h2) sda_oe_ff <= 1'b0; // [RULE_02]
            if (qtr_ff == 2'h3) begin
              active_ff        <= 1'b0; // [RULE_06]
              cmd_ff[CMD_STOP] <= 1'b0;
              state_ff         <= M_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    line_lo_ff <= 1'b0;
  end

  assign link.m_scl_o  = line_lo_ff;
  assign link.m_sda_o  = line_lo_ff;
  assign link.m_scl_oe = scl_oe_ff;
  assign link.m_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// [eeprom_i2c_link_asserts.sv]
/*
  Wire checks on the two-wire link between the bus master and the slave.
  Assumes the signals of one i2c_link_if and the shared aclk and aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_link_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic open_ff;

  // Tracks from the raw wires whether the bus lies between a START and a STOP.
  always_ff @(posedge aclk) begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_ff <= 1'b0;
    end else if (scl && scl_q_ff && (sda != sda_q_ff)) begin
      open_ff <= !sda;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  idle_quiet_a: assert property (s_sda_oe |-> open_ff)
    else $error("slave drove data outside a transaction");
  open_drain_a: assert property (!(m_scl_oe && m_scl_o) && !(m_sda_oe && m_sda_o) && !(s_sda_oe && s_sda_o))
    else $error("a driver pushes a line high");
  drive_on_low_a: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("slave drive began with clock high");
  high_stable_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data moved with clock high");
  ack_hold_a: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("slave low drive too short");
  start_hold_a: assert property (scl && $fell(sda) |-> scl [*8])
    else $error("clock fell too soon after start");
  stop_hold_a: assert property (scl && $rose(sda) |-> sda [*8])
    else $error("data fell too soon after stop");
  out_hold_a: assert property ($fell(scl) |-> $stable(s_sda_oe) [*3])
    else $error("slave data changed too soon after clock fall");
  clk_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule
`default_nettype wire

// [eeprom_i2c_slave_front_end_bench.sv]
/*
  Bench: AXI4-Lite driver for the master, slave pin stimulus and a byte model.
  Assumes both ends share one 25 MHz aclk and meet in i2c_link_if.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_slave_front_end_bench;
  import eeprom_i2c_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b1, write_protect = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [2:0]  device_select_pins = 3'h0, high_memory_address_bits_ff;
  logic [7:0]  rd_byte, wr_byte_ff, sa, wa, d;
  logic [7:0]  mem [4];
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, ready_ff, busy_ff, wr_valid_ff, wr_first_ff, rd_req_ff;
  logic [9:0]  exp_q [$];
  int          error_cnt = 0, checks = 0, seed, ptr = 0, n;
  assign rd_byte = mem[ptr[1:0]];
  i2c_link_if link ();
  eeprom_i2c_slave #(.WR_CYCLES(3000), .SEL_USED(3'h3)) u_eeprom_i2c_slave (.aclk, .aresetn, .link, .supply_ok,
    .write_protect, .device_select_pins, .rd_byte, .ready_ff, .busy_ff, .wr_valid_ff, .wr_first_ff, .wr_byte_ff,
    .rd_req_ff, .high_memory_address_bits_ff);
  i2c_bus_master u_i2c_bus_master (.aclk, .aresetn, .link, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  eeprom_i2c_link_asserts u_eeprom_i2c_link_asserts (.aclk, .aresetn, .m_scl_o(link.m_scl_o),
    .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o),
    .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    st = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // Posts one command word; the link ack bit is only judged when a byte was sent.
  task automatic cmd(input logic [7:0] c, input logic [7:0] t, input logic nk);
    wr(TXD_OFS, {24'h0, t});
    wr(CTRL_OFS, {24'h0, c});
    do rd(STAT_OFS); while (st[ST_BUSY] !== 1'b0);
    if (c[1]) chk("nack", st[ST_NACK], nk);
  endtask
  task automatic wait_ready();
    n = 0;
    while (ready_ff !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk("ready_time", n <= PU_CYC + 8, 1);
  endtask
  // Every acked write byte must match the model queue; a byte with none queued is a fault.
  always @(posedge aclk) begin
    if (rd_req_ff) ptr <= ptr + 1;
    if (wr_valid_ff) chk("wr_byte", {wr_first_ff, wr_byte_ff}, exp_q.size() != 0 ? exp_q.pop_front() : 10'h3ff);
  end
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    seed = 32'h8d90c80f;
    device_select_pins = 3'($random(seed));
    for (int i = 0; i < 4; i++) mem[i] = 8'($random(seed));
    sa = {TYPE_CODE, 1'($random(seed)), device_select_pins[1:0], 1'b0};
    wa = 8'($random(seed));
    d = 8'($random(seed));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wait_ready();
    rd(4'hc);
    chk("rd_unmapped", {st[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(4'hc, 32'h0);
    chk("wr_unmapped", resp, RESP_SLVERR);
    cmd(8'h02, sa, 1'b1);
    cmd(8'h03, sa, 1'b0);
    chk("active", st[ST_ACTIVE], 1'b1);
    chk("high_bits", high_memory_address_bits_ff, {sa[3], 2'b00});
    exp_q.push_back({2'b01, wa});
    cmd(8'h02, wa, 1'b0);
    exp_q.push_back({2'b00, d});
    cmd(8'h0a, d, 1'b0);
    chk("released", st[ST_ACTIVE], 1'b0);
    repeat (20) @(posedge aclk);
    chk("busy", busy_ff, 1'b1);
    cmd(8'h0b, sa, 1'b1);
    n = 0;
    while (busy_ff !== 1'b0 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    chk("busy_end", n < 3000, 1);
    cmd(8'h0b, sa, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'hb0 : (i == 1) ? 8'h20 : {4'ha, 1'b0, ~device_select_pins[1:0], 1'b0};
      cmd(8'h0b, d, 1'b1);
    end
    cmd(8'h03, sa, 1'b0);
    exp_q.push_back({2'b01, wa});
    cmd(8'h02, wa, 1'b0);
    cmd(8'h03, sa | 8'h01, 1'b0);
    cmd(8'h04, 8'h0, 1'b0);
    chk("rd0", st[15:8], mem[0]);
    cmd(8'h1c, 8'h0, 1'b0);
    chk("rd1", st[15:8], mem[1]);
    write_protect <= 1'b1;
    cmd(8'h03, sa, 1'b0);
    exp_q.push_back({2'b01, wa});
    cmd(8'h02, wa, 1'b0);
    cmd(8'h0a, wa, 1'b1);
    repeat (20) @(posedge aclk);
    chk("wp_busy", busy_ff, 1'b0);
    write_protect <= 1'b0;
    supply_ok <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("por_ready", ready_ff, 1'b0);
    supply_ok <= 1'b1;
    wait_ready();
    cmd(8'h0b, sa, 1'b0);
    chk("queue_left", exp_q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
